// ==== logic/irq_source_control_regs.sv ====
// per-source interrupt mask, priority and trigger control with apb access
`timescale 1ns/1ps
module irq_source_control_regs
	import irq_ctl_pkg::*;
	#(
	parameter int ADDR_W = 12
	)
	(
	// clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// raw request lines
	input wire logic [2:0] timer_req_i,
	input wire logic [1:0] dma_req_i,
	input wire logic ext_request_zero_i,
	input wire logic ext_request_one_i,
	input wire logic ext_request_two_i,
	input wire logic ext_request_three_i,
	input wire logic ext_request_four_i,
	input wire logic watchdog_req_i,
	input wire logic serial_req_i,
	// acknowledge from the priority logic, one pulse per source
	input wire logic [SRC_COUNT-1:0] src_ack_i,
	// gated requests and their attributes
	output logic [SRC_COUNT-1:0] src_req_o,
	output logic [SRC_COUNT*PRIO_W-1:0] src_prio_o,
	output logic [SRC_COUNT*8-1:0] src_type_o,
	output logic [1:0] special_nesting_enable_o,
	output logic [1:0] cascade_enable_o,
	output logic slave_mode_o,
	// acknowledge pins shared with inputs two and three
	output logic ack_out_zero_low_o,
	output logic ack_out_zero_oe_o,
	output logic ack_out_one_low_o,
	output logic ack_out_one_oe_o
	);

	// ==========================================================
	// reset release
	logic rst_meta_r;
	logic rst_n_r;

	// two stages so the release never lands mid-cycle on the registers
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// ==========================================================
	// state
	logic [CTL_W-1:0] ctl_r [SRC_COUNT];
	logic [CTL_W-1:0] eff_ctl [SRC_COUNT];
	logic [SRC_COUNT-1:0] raw_req;
	logic [SRC_COUNT-1:0] prev_r;
	logic [SRC_COUNT-1:0] pend_r;
	logic [SRC_COUNT-1:0] req_r;
	logic [SRC_COUNT-1:0] block_view;
	logic [SRC_COUNT-1:0] casc_block;
	logic slave_r;
	logic [1:0] ack_pulse_r;
	logic [31:0] prdata_r;

	// ==========================================================
	// apb decode
	logic [9:0] idx;
	logic aligned;
	logic setup_ph;
	logic access_ph;
	logic wr_acc;
	logic ctl_hit;
	logic [3:0] ctl_src;
	logic mask_hit;
	logic req_hit;
	logic mode_hit;
	logic any_hit;

	assign idx = paddr_i[11:2];
	assign aligned = (paddr_i[1:0] == 2'b00);
	assign setup_ph = psel_i && !penable_i;
	assign access_ph = psel_i && penable_i;
	assign wr_acc = ce_i && access_ph && pwrite_i && any_hit;
	assign mask_hit = aligned && (idx == IDX_MASK);
	assign req_hit = aligned && (idx == IDX_REQ);
	assign mode_hit = aligned && (idx == IDX_MODE);
	assign any_hit = ctl_hit || mask_hit || req_hit || mode_hit;

	// shared offsets select timers in slave mode and inputs zero, one in master mode
	always_comb
	begin
		ctl_hit = aligned;
		ctl_src = 4'(SRC_TMR0);
		if (idx == IDX_TMR0)
			ctl_src = 4'(SRC_TMR0);
		else if (idx == IDX_DMA0)
			ctl_src = 4'(SRC_DMA0);
		else if (idx == IDX_DMA1)
			ctl_src = 4'(SRC_DMA1);
		else if (idx == IDX_EXT0)
			ctl_src = slave_r ? 4'(SRC_TMR1) : 4'(SRC_EXT0);
		else if (idx == IDX_EXT1)
			ctl_src = slave_r ? 4'(SRC_TMR2) : 4'(SRC_EXT1);
		else if (idx == IDX_EXT2)
			ctl_src = 4'(SRC_EXT2);
		else if (idx == IDX_EXT3)
			ctl_src = 4'(SRC_EXT3);
		else if (idx == IDX_EXT4)
			ctl_src = 4'(SRC_EXT4);
		else if (idx == IDX_WDOG)
			ctl_src = 4'(SRC_WDOG);
		else if (idx == IDX_SER)
			ctl_src = 4'(SRC_SER);
		else
			ctl_hit = 1'b0;
	end

	// zero wait states; read data is captured in the setup cycle
	assign pready_o = access_ph;
	assign pslverr_o = access_ph && !any_hit;
	assign prdata_o = prdata_r;

	// ==========================================================
	// raw request collection
	assign raw_req[SRC_TMR0] = timer_req_i[0];
	assign raw_req[SRC_TMR1] = timer_req_i[1];
	assign raw_req[SRC_TMR2] = timer_req_i[2];
	assign raw_req[SRC_DMA0] = dma_req_i[0];
	assign raw_req[SRC_DMA1] = dma_req_i[1];
	assign raw_req[SRC_EXT0] = ext_request_zero_i;
	assign raw_req[SRC_EXT1] = ext_request_one_i;
	assign raw_req[SRC_EXT2] = ext_request_two_i;
	assign raw_req[SRC_EXT3] = ext_request_three_i;
	assign raw_req[SRC_EXT4] = ext_request_four_i;
	assign raw_req[SRC_WDOG] = watchdog_req_i;
	assign raw_req[SRC_SER] = serial_req_i;

	// pins two and three carry acknowledges while the paired input cascades
	assign casc_block = SRC_COUNT'({ctl_r[SRC_EXT1][CASC_BIT], ctl_r[SRC_EXT0][CASC_BIT]})
		<< SRC_EXT2;

	// ==========================================================
	// per-source control, trigger and gating
	genvar gi;
	generate
		for (gi = 0; gi < SRC_COUNT; gi++)
		begin : g_src
			localparam logic [CTL_W-1:0] WMASK = (gi == SRC_EXT0 || gi == SRC_EXT1) ?
				WMASK_FULL : (gi >= SRC_EXT2 && gi <= SRC_EXT4) ? WMASK_LEVEL : WMASK_BASIC;
			localparam bit IS_EXT = (gi >= SRC_EXT0 && gi <= SRC_EXT4);
			localparam bit IS_SHARED = (gi == SRC_TMR1 || gi == SRC_TMR2);
			logic reg_wr;
			logic mask_wr;
			logic rise;
			logic fire;

			assign reg_wr = wr_acc && ctl_hit && (ctl_src == 4'(gi));
			assign mask_wr = wr_acc && mask_hit && !(IS_SHARED && !slave_r);
			// master mode: timers one and two follow the group register
			assign eff_ctl[gi] = (IS_SHARED && !slave_r) ? ctl_r[SRC_TMR0] : ctl_r[gi];
			assign block_view[gi] = eff_ctl[gi][BLOCK_BIT];
			assign rise = raw_req[gi] && !prev_r[gi];
			// edge mode latches the rise; level mode passes the line through
			assign fire = (IS_EXT && !eff_ctl[gi][LEVEL_BIT]) ? pend_r[gi] : raw_req[gi];

			// block bit written here or through the mirror register
			always_ff @(posedge sys_clk_i or negedge rst_n_r)
			begin
				if (!rst_n_r)
					ctl_r[gi] <= CTL_RESET;
				else if (ce_i && reg_wr)
					ctl_r[gi] <= pwdata_i[CTL_W-1:0] & WMASK;
				else if (ce_i && mask_wr)
					ctl_r[gi][BLOCK_BIT] <= pwdata_i[gi];
			end

			// rising-edge latch, the set wins over a same-cycle acknowledge
			always_ff @(posedge sys_clk_i or negedge rst_n_r)
			begin
				if (!rst_n_r)
				begin
					prev_r[gi] <= 1'b0;
					pend_r[gi] <= 1'b0;
				end
				else if (ce_i)
				begin
					prev_r[gi] <= raw_req[gi];
					if (IS_EXT && rise)
						pend_r[gi] <= 1'b1;
					else if (src_ack_i[gi])
						pend_r[gi] <= 1'b0;
				end
			end

			// gated request, blocked by the block bit or by a cascade pin takeover
			always_ff @(posedge sys_clk_i or negedge rst_n_r)
			begin
				if (!rst_n_r)
					req_r[gi] <= 1'b0;
				else if (ce_i)
					req_r[gi] <= fire && !eff_ctl[gi][BLOCK_BIT] && !casc_block[gi];
			end

			assign src_prio_o[gi*PRIO_W +: PRIO_W] = eff_ctl[gi][PRIO_LSB +: PRIO_W];
			assign src_type_o[gi*8 +: 8] = TYPE_TABLE[gi];
		end
	endgenerate

	assign src_req_o = req_r;

	// ==========================================================
	// mode register and read path
	logic [15:0] ctl_read;

	// reset leaves the controller in master mode
	always_ff @(posedge sys_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			slave_r <= 1'b0;
		else if (wr_acc && mode_hit)
			slave_r <= pwdata_i[MODE_SLAVE_BIT];
	end

	// serial port register keeps its fixed one in bit four
	assign ctl_read = (ctl_src == 4'(SRC_SER)) ?
		(16'(ctl_r[SRC_SER]) | SER_RESET & 16'h0010) : 16'(ctl_r[ctl_src]);

	always_ff @(posedge sys_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			prdata_r <= 32'h00000000;
		else if (ce_i && setup_ph && !pwrite_i)
		begin
			if (ctl_hit)
				prdata_r <= 32'(ctl_read);
			else if (mask_hit)
				prdata_r <= 32'(block_view);
			else if (req_hit)
				prdata_r <= 32'(req_r);
			else if (mode_hit)
				prdata_r <= 32'(slave_r);
			else
				prdata_r <= 32'h00000000;
		end
	end

	// ==========================================================
	// cascade and special nesting outputs
	assign special_nesting_enable_o = {ctl_r[SRC_EXT1][NEST_BIT], ctl_r[SRC_EXT0][NEST_BIT]};
	assign cascade_enable_o = {ctl_r[SRC_EXT1][CASC_BIT], ctl_r[SRC_EXT0][CASC_BIT]};
	assign slave_mode_o = slave_r;

	// one-cycle low acknowledge on the paired pin for a cascaded input
	always_ff @(posedge sys_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			ack_pulse_r <= 2'b00;
		else if (ce_i)
			ack_pulse_r <= cascade_enable_o & src_ack_i[SRC_EXT1:SRC_EXT0];
	end

	assign ack_out_zero_low_o = !ack_pulse_r[0];
	assign ack_out_zero_oe_o = cascade_enable_o[0];
	assign ack_out_one_low_o = !ack_pulse_r[1];
	assign ack_out_one_oe_o = cascade_enable_o[1];

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_r);

	chk_serial_block: assert property (
		ce_i && block_view[SRC_SER] |=> !req_r[SRC_SER])
		else $error("serial request passed while blocked");

	chk_wdog_block: assert property (
		ce_i && !block_view[SRC_WDOG] && !casc_block[SRC_WDOG] && watchdog_req_i
		|=> req_r[SRC_WDOG])
		else $error("unblocked watchdog request lost");

	chk_reset_prio: assert property (
		$rose(rst_n_r) |-> (src_prio_o == {SRC_COUNT{PRIO_LOWEST}}) && (block_view == '1))
		else $error("priority or block bit wrong after reset");

	chk_serial_fixed: assert property (
		ce_i && setup_ph && !pwrite_i && ctl_hit && ctl_src == 4'(SRC_SER)
		|=> prdata_o[SER_FIXED_BIT])
		else $error("serial control bit four read as zero");

	chk_edge_latch: assert property (
		ce_i && !ctl_r[SRC_EXT4][LEVEL_BIT] && !ctl_r[SRC_EXT4][BLOCK_BIT]
		&& ext_request_four_i && !prev_r[SRC_EXT4]
		##1 ce_i && !ctl_r[SRC_EXT4][LEVEL_BIT] && !ctl_r[SRC_EXT4][BLOCK_BIT]
		|=> req_r[SRC_EXT4])
		else $error("rising edge on input four not requested");

	chk_level_follow: assert property (
		ce_i && ctl_r[SRC_EXT0][LEVEL_BIT] && !ctl_r[SRC_EXT0][BLOCK_BIT]
		|=> req_r[SRC_EXT0] == $past(ext_request_zero_i))
		else $error("level request on input zero not followed");

	chk_mask_mirror: assert property (
		wr_acc && ctl_hit && ctl_src == 4'(SRC_EXT2)
		|=> block_view[SRC_EXT2] == $past(pwdata_i[BLOCK_BIT]))
		else $error("mirror does not show written block bit");

	chk_timer_share: assert property (
		!slave_r |-> src_prio_o[SRC_TMR1*PRIO_W +: PRIO_W] == src_prio_o[PRIO_W-1:0]
		&& src_prio_o[SRC_TMR2*PRIO_W +: PRIO_W] == src_prio_o[PRIO_W-1:0])
		else $error("timers disagree in master mode");

	chk_slave_timer: assert property (
		slave_r && wr_acc && ctl_hit && idx == IDX_EXT0
		|=> ctl_r[SRC_TMR1] == ($past(pwdata_i[CTL_W-1:0]) & WMASK_BASIC)
		&& $stable(ctl_r[SRC_EXT0]))
		else $error("slave timer one register not written");

	chk_cascade_ack: assert property (
		ce_i && cascade_enable_o[0] && src_ack_i[SRC_EXT0]
		|=> !ack_out_zero_low_o && ack_out_zero_oe_o ##1 !ce_i || ack_out_zero_low_o)
		else $error("cascade acknowledge pulse wrong");

	// gating of the dma channels, watchdog and timers one and two, cascade pin takeover, level input two and the nesting bit write
	chk_dma0_block: assert property (
		ce_i && block_view[SRC_DMA0]
		|=> !req_r[SRC_DMA0])
		else $error("dma channel zero request passed while blocked");

	chk_dma1_block: assert property (
		ce_i && block_view[SRC_DMA1]
		|=> !req_r[SRC_DMA1])
		else $error("dma channel one request passed while blocked");

	chk_wdog_blocked: assert property (
		ce_i && block_view[SRC_WDOG]
		|=> !req_r[SRC_WDOG])
		else $error("watchdog request passed while blocked");

	chk_timer_group: assert property (
		ce_i && !slave_r && block_view[SRC_TMR0]
		|=> !req_r[SRC_TMR1] && !req_r[SRC_TMR2])
		else $error("timer request passed while group is blocked");

	chk_cascade_gate: assert property (
		ce_i && cascade_enable_o[0]
		|=> !req_r[SRC_EXT2])
		else $error("pin two requested while it carries an acknowledge");

	chk_level_two: assert property (
		ce_i && ctl_r[SRC_EXT2][LEVEL_BIT] && !ctl_r[SRC_EXT2][BLOCK_BIT] && !cascade_enable_o[0]
		|=> req_r[SRC_EXT2] == $past(ext_request_two_i))
		else $error("level request on input two not followed");

	chk_nest_write: assert property (
		wr_acc && ctl_hit && ctl_src == 4'(SRC_EXT0)
		|=> special_nesting_enable_o[0] == $past(pwdata_i[NEST_BIT]))
		else $error("special nesting bit of input zero not written");

endmodule

// ==== inc/irq_ctl_pkg.sv ====
// constants for the per-source interrupt control register block
// How it works
// - serial port may request only while its block bit is 0
// - priority field 000b is highest, 111b lowest, binary order between
// - every priority field resets to level 7
// - watchdog may request only while its block bit is clear
// - watchdog, external, timer and dma control registers reset to 000Fh
// - external input four is vectored as type 10h
// - input four: level select 1 is high-level, 0 is rising-edge
// - inputs two, three are types 0eh, 0fh; acknowledge outputs in cascade mode
// - inputs two, three: level select as input four; source holds line high
// - inputs zero, one are types 0ch, 0dh and pair with acknowledge pins
// - inputs zero, one: special nesting bit 1 enables special nested operation
// - inputs zero, one: cascade bit 1 enables cascade operation
// - inputs zero, one: level select as above; edge source holds line high
// - each block bit is mirrored in the mask register, both ways
// - master mode: timers use types 08h, 12h, 13h, one shared control
// - slave mode: each timer has its own control register
// - dma channels are types 0ah, 0bh with own control registers
// - serial port control resets to 001Fh, bit four reads 1
package irq_ctl_pkg;

	// ==========================================================
	// sources
	localparam int SRC_COUNT = 12;
	localparam int SRC_TMR0 = 0;
	localparam int SRC_TMR1 = 1;
	localparam int SRC_TMR2 = 2;
	localparam int SRC_DMA0 = 3;
	localparam int SRC_DMA1 = 4;
	localparam int SRC_EXT0 = 5;
	localparam int SRC_EXT1 = 6;
	localparam int SRC_EXT2 = 7;
	localparam int SRC_EXT3 = 8;
	localparam int SRC_EXT4 = 9;
	localparam int SRC_WDOG = 10;
	localparam int SRC_SER = 11;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [9:0] IDX_TMR0 = 10'h032;
	localparam logic [9:0] IDX_DMA0 = 10'h034;
	localparam logic [9:0] IDX_DMA1 = 10'h036;
	localparam logic [9:0] IDX_EXT0 = 10'h038;
	localparam logic [9:0] IDX_EXT1 = 10'h03A;
	localparam logic [9:0] IDX_EXT2 = 10'h03C;
	localparam logic [9:0] IDX_EXT3 = 10'h03E;
	localparam logic [9:0] IDX_EXT4 = 10'h040;
	localparam logic [9:0] IDX_WDOG = 10'h042;
	localparam logic [9:0] IDX_SER = 10'h044;
	localparam logic [9:0] IDX_MASK = 10'h020;
	localparam logic [9:0] IDX_REQ = 10'h021;
	localparam logic [9:0] IDX_MODE = 10'h022;

	// ==========================================================
	// field layout and reset values
	localparam int CTL_W = 7;
	localparam int PRIO_LSB = 0;
	localparam int PRIO_W = 3;
	localparam int BLOCK_BIT = 3;
	localparam int LEVEL_BIT = 4;
	localparam int CASC_BIT = 5;
	localparam int NEST_BIT = 6;
	localparam int SER_FIXED_BIT = 4;
	localparam int MODE_SLAVE_BIT = 0;
	localparam logic [CTL_W-1:0] CTL_RESET = 7'h0F;
	localparam logic [CTL_W-1:0] WMASK_BASIC = 7'h0F;
	localparam logic [CTL_W-1:0] WMASK_LEVEL = 7'h1F;
	localparam logic [CTL_W-1:0] WMASK_FULL = 7'h7F;
	localparam logic [15:0] SER_RESET = 16'h001F;
	localparam logic [PRIO_W-1:0] PRIO_LOWEST = 3'h7;

	// ==========================================================
	// vector types, indexed by source
	localparam logic [7:0] TYPE_TABLE [SRC_COUNT] = '{
		8'h08, 8'h12, 8'h13, 8'h0A, 8'h0B, 8'h0C,
		8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h14
	};

endpackage

// ==== verification/ext_src_model.sv ====
// far-side model of the five external request sources
`timescale 1ns/1ps
module ext_src_model
	(
	// clock
	input wire logic clk_i,
	// raise command and acknowledge, one bit per line
	input wire logic [4:0] fire_i,
	input wire logic [4:0] ack_i,
	// request lines
	output logic [4:0] line_o
	);

	// ==========================================================
	// request hold
	initial line_o = 5'h00;
	// a raised line stays high until its acknowledge, so no request is lost
	always @(posedge clk_i)
		line_o <= (line_o & ~ack_i) | fire_i;
endmodule

// ==== verification/tb_irq_source_control_regs.sv ====
// self-checking bench for the interrupt source control registers
`timescale 1ns/1ps
module tb_irq_source_control_regs;
	import irq_ctl_pkg::*;

	// ==========================================================
	// signals
	logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, slave_mode;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic er, ce;
	logic [2:0] timer_req;
	logic [1:0] dma_req, nest_en, casc_en;
	logic wdog_req, ser_req, ack0_n, ack0_oe, ack1_n, ack1_oe;
	logic [11:0] src_ack, src_req;
	logic [35:0] src_prio;
	logic [95:0] src_type;
	logic [4:0] fire, ext;
	logic [31:0] seed = 32'h0000000A;
	logic [9:0] regs [10] = '{IDX_TMR0, IDX_DMA0, IDX_DMA1, IDX_EXT0, IDX_EXT1,
		IDX_EXT2, IDX_EXT3, IDX_EXT4, IDX_WDOG, IDX_SER};
	int srcs [10] = '{0, 3, 4, 5, 6, 7, 8, 9, 10, 11};
	logic [7:0] types [10] = '{8'h08, 8'h12, 8'h13, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
		8'h0E, 8'h0F, 8'h10};
	int n_mismatch = 0;
	int n_tests = 0;
	logic [31:0] v;

	// ==========================================================
	// clock, design and far side
	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;

	irq_source_control_regs irq_source_control_regs_inst (.sys_clk_i(sys_clk),
		.resetn_i(resetn), .ce_i(ce), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .timer_req_i(timer_req),
		.dma_req_i(dma_req), .ext_request_zero_i(ext[0]), .ext_request_one_i(ext[1]),
		.ext_request_two_i(ext[2]), .ext_request_three_i(ext[3]),
		.ext_request_four_i(ext[4]), .watchdog_req_i(wdog_req), .serial_req_i(ser_req),
		.src_ack_i(src_ack), .src_req_o(src_req), .src_prio_o(src_prio),
		.src_type_o(src_type), .special_nesting_enable_o(nest_en),
		.cascade_enable_o(casc_en), .slave_mode_o(slave_mode),
		.ack_out_zero_low_o(ack0_n), .ack_out_zero_oe_o(ack0_oe),
		.ack_out_one_low_o(ack1_n), .ack_out_one_oe_o(ack1_oe));

	ext_src_model ext_src_model_inst (.clk_i(sys_clk), .fire_i(fire),
		.ack_i(src_ack[9:5]), .line_o(ext));

	// ==========================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// readback expectation: only the documented bits stick
	function automatic logic [31:0] exp_rd(input logic [9:0] a, input logic [31:0] d);
		if (a == IDX_EXT0 || a == IDX_EXT1)
			return d & 32'h0000007F;
		if (a == IDX_EXT2 || a == IDX_EXT3 || a == IDX_EXT4)
			return d & 32'h0000001F;
		if (a == IDX_SER)
			return (d & 32'h0000000F) | 32'h00000010;
		return d & 32'h0000000F;
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {a, 2'b00};
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e, "register read");
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic tally_and_finish;
		if (n_mismatch == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================================
	// watchdog against hangs
	initial
	begin
		#500000;
		n_mismatch++;
		tally_and_finish();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		ce = 1'b1;
		{timer_req, dma_req, wdog_req, ser_req, src_ack, fire} = '0;
		resetn = 1'b0;
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		// reset values, priorities and fixed types
		for (int i = 0; i < 10; i++)
			rdchk(regs[i], regs[i] == IDX_SER ? 32'h1F : 32'h0F);
		chk(src_prio, {12{3'h7}}, "reset priority");
		for (int i = 0; i < 10; i++)
			chk(src_type[8*i+:8], types[i], "vector type");
		apb(1'b0, 10'h3FF, 32'h0);
		chk({rd, 31'h0, er}, {32'h0, 31'h0, 1'b1}, "unmapped read");
		// random write and readback, priority outputs follow
		for (int p = 0; p < 3; p++)
			for (int i = 0; i < 10; i++)
			begin
				seed = xs(seed);
				apb(1'b1, regs[i], exp_rd(regs[i], seed));
				rdchk(regs[i], exp_rd(regs[i], seed));
				chk(src_prio[3*srcs[i]+:3], seed[2:0], "priority out");
			end
		// mask mirror both ways
		apb(1'b1, IDX_DMA0, 32'h0B);
		apb(1'b1, IDX_DMA1, 32'h03);
		apb(1'b0, IDX_MASK, 32'h0);
		chk(rd[4:3], 2'b01, "mirror read");
		apb(1'b1, IDX_MASK, 32'h10);
		rdchk(IDX_DMA1, 32'h0B);
		rdchk(IDX_DMA0, 32'h03);
		// internal sources blocked then allowed
		apb(1'b1, IDX_WDOG, 32'h0F);
		apb(1'b1, IDX_SER, 32'h1F);
		wdog_req <= 1'b1;
		ser_req <= 1'b1;
		settle(2);
		chk(src_req[11:10], 2'b00, "blocked internal");
		apb(1'b1, IDX_WDOG, 32'h00);
		apb(1'b1, IDX_SER, 32'h15);
		settle(2);
		chk(src_req[11:10], 2'b11, "open internal");
		// timer group shares one field; dma channels their own
		apb(1'b1, IDX_TMR0, 32'h05);
		apb(1'b1, IDX_DMA0, 32'h01);
		apb(1'b1, IDX_DMA1, 32'h0A);
		timer_req <= 3'h7;
		dma_req <= 2'h3;
		settle(2);
		chk(src_req[4:0], 5'h0F, "timer dma req");
		chk(src_prio[14:0], {3'h2, 3'h1, 3'h5, 3'h5, 3'h5}, "group prio");
		rdchk(IDX_REQ, 32'h00000C0F);
		// enable low freezes the timer and dma request flops
		@(posedge sys_clk);
		ce <= 1'b0;
		{timer_req, dma_req, wdog_req, ser_req} <= '0;
		settle(2);
		chk(src_req[4:0], 5'h0F, "frozen by enable");
		@(posedge sys_clk);
		ce <= 1'b1;
		settle(2);
		chk(src_req, 12'h000, "released requests");
		// edge-mode input four: held until acknowledged
		apb(1'b1, IDX_EXT4, 32'h00);
		fire <= 5'h10;
		@(posedge sys_clk);
		fire <= 5'h00;
		settle(3);
		chk(src_req[9], 1'b1, "edge req");
		@(posedge sys_clk);
		src_ack <= 12'h200;
		@(posedge sys_clk);
		src_ack <= 12'h000;
		settle(3);
		chk(src_req[9], 1'b0, "edge acked");
		// level mode input two; input zero leaves cascade so pin two requests
		apb(1'b1, IDX_EXT0, 32'h0F);
		apb(1'b1, IDX_EXT2, 32'h10);
		fire <= 5'h04;
		@(posedge sys_clk);
		fire <= 5'h00;
		settle(2);
		chk(src_req[7], 1'b1, "level req");
		@(posedge sys_clk);
		src_ack <= 12'h080;
		@(posedge sys_clk);
		src_ack <= 12'h000;
		settle(2);
		chk(src_req[7], 1'b0, "level drop");
		// cascade and special nesting on input zero
		apb(1'b1, IDX_EXT0, 32'h60);
		apb(1'b1, IDX_EXT1, 32'h10);
		#1;
		chk({nest_en, casc_en, ack0_oe, ack1_oe}, 6'h16, "cascade cfg");
		chk({ack0_n, ack1_n}, 2'h3, "ack idle");
		@(posedge sys_clk);
		fire <= 5'h04;
		@(posedge sys_clk);
		fire <= 5'h00;
		settle(2);
		chk(src_req[7], 1'b0, "pin taken by ack");
		@(posedge sys_clk);
		src_ack <= 12'h020;
		@(posedge sys_clk);
		src_ack <= 12'h000;
		#1;
		chk(ack0_n, 1'b0, "ack pulse low");
		settle(1);
		chk(ack0_n, 1'b1, "ack pulse end");
		// slave mode: per-timer controls
		apb(1'b1, IDX_MODE, 32'h1);
		apb(1'b1, IDX_EXT0, 32'h02);
		apb(1'b1, IDX_EXT1, 32'h04);
		rdchk(IDX_EXT0, 32'h02);
		chk({slave_mode, src_prio[8:3]}, {1'b1, 3'h4, 3'h2}, "slave timers");
		rdchk(IDX_MODE, 32'h00000001);
		tally_and_finish();
	end
endmodule
